// File: rxg_config_regs.sv
// Purpose: Receiver front control, first-stage gain and later-stage gain registers with their decoded controls
// Assumes: All inputs synchronous to ref_clk; command inputs are one-cycle pulses
// Notes:   Later-stage gain takes effect only on Reset Rx Gain or Set Default; decoded gains lag the active code by one cycle
//
// Contract
// - Front bit 7 set puts the receiver into low power operation.
// - Front bit 6 selects differential LF or split inputs to AM and PM.
// - Front bit 5 applies the LF signal to the receiver input.
// - Bit 4 enables AGC; bit 3 chooses whole period or first eight pulses.
// - Bit 2 picks preset-based or reset-based gain control algorithm.
// - Bit 1 starts squelch 18.88 us after transmit, stops at mask timer expiry.
// - Bit 0 picks mixer clock; single-ended mode always uses internal signal.
// - AM first-stage code: 0 full, 1-6 cut 2.5 dB steps, 7 boosts.
// - PM first-stage code uses the same coding as the AM field.
// - First-stage bit 1 clips output of first and second stages.
// - Bit 0 forces later stages to -6 dB, max window; restart after clearing.
// - AM later-stage codes 1-4 widen window, 5-A also cut stage gain.
// - PM later-stage field follows the same coding as the AM field.
// - Later-stage register reaches gain logic only on Reset Rx Gain command.
// - All three registers return to defaults at power-up and Set Default.
// - Registers are read/write at addresses 0Bh, 0Ch and 0Dh.
`timescale 1ns/1ps
`include "rxg_params.svh"
module rxg_config_regs
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic [`RXG_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]              wrData,
  input  wire logic                    wrStrobe,
  input  wire logic                    rdStrobe,
  output logic      [7:0]              rdData,
  input  wire logic                    setDefaultCmd,
  input  wire logic                    resetRxGainCmd,
  input  wire logic                    receiverRestart,
  input  wire logic                    singleEndedMode,
  input  wire logic                    txEnd,
  input  wire logic                    maskTimerExpired,
  input  wire logic                    rxActive,
  input  wire logic                    subCarrierPulse,
  output logic                         lowPowerReceive,
  output logic                         lowfreqSplitSelect,
  output logic                         lfInputEnable,
  output logic                         agcEnable,
  output logic                         agcResetAlgorithm,
  output logic                         agcActive,
  output logic                         squelchActive,
  output logic                         phaseMixerClockSelect,
  output logic      [2:0]              amFirstStageGain,
  output logic      [2:0]              pmFirstStageGain,
  output logic                         clipEnable,
  output logic                         forcedPeerGainCut,
  output logic                         restartPending,
  output logic      [3:0]              amLaterStageGain,
  output logic      [3:0]              pmLaterStageGain,
  output logic      [3:0]              amWindowSteps,
  output logic      [3:0]              pmWindowSteps,
  output logic      [2:0]              amStageCut,
  output logic      [2:0]              pmStageCut
);

  ////////////////////////////////////////////////////////////////////////////
  // Timing: least delay rounds up to whole cycles
  localparam int SQ_CYCLES = (`RXG_SQ_DELAY_PS * `RXG_CLK_MHZ + 999999) / 1000000;
  localparam logic [`RXG_SQ_CNT_W-1:0] SQ_LAST = `RXG_SQ_CNT_W'(SQ_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]               front;
    logic [7:0]               first;
    logic [7:0]               later;
    logic [7:0]               laterActive;
    logic [7:0]               rdData;
    rxg_pkg::rxg_squelch_t    sqState;
    logic [`RXG_SQ_CNT_W-1:0] sqCnt;
    logic [3:0]               agcPulses;
    logic                     agcOn;
    logic                     mixInternal;
    logic                     restartPending;
    logic [1:0][3:0]          window;
    logic [1:0][2:0]          cut;
  } rxg_state_t;

  rxg_state_t state;
  rxg_state_t next_state;

  rxg_gain_if gainBus ();

  logic wrFront;
  logic wrFirst;
  logic wrLater;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wrFront = wrStrobe && (regAddr == `RXG_ADDR_FRONT);
  assign wrFirst = wrStrobe && (regAddr == `RXG_ADDR_FIRST);
  assign wrLater = wrStrobe && (regAddr == `RXG_ADDR_LATER);

  // Decoder sees the active code, never the freshly written one
  assign gainBus.laterCode[0] = state.laterActive[`RXG_F_AMLATER];
  assign gainBus.laterCode[1] = state.laterActive[`RXG_F_PMLATER];
  assign gainBus.forcedCut    = state.first[`RXG_B_FORCECUT];

  rxg_gain_decode uDecode
  (
    .gain (gainBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_state = state;

    // Register writes; Set Default overrides a write in the same cycle
    if (wrFront)
      next_state.front = wrData;
    if (wrFirst)
      next_state.first = wrData;
    if (wrLater)
      next_state.later = wrData;
    if (resetRxGainCmd)
      next_state.laterActive = state.later;
    if (setDefaultCmd)
    begin
      next_state.front       = `RXG_RST_FRONT;
      next_state.first       = `RXG_RST_FIRST;
      next_state.later       = `RXG_RST_LATER;
      next_state.laterActive = `RXG_RST_LATER;
    end

    // Read data stand in the cycle after the strobe only
    next_state.rdData = `RXG_READ_UNMAPPED;
    if (rdStrobe)
    begin
      case (regAddr)
        `RXG_ADDR_FRONT: next_state.rdData = state.front;
        `RXG_ADDR_FIRST: next_state.rdData = state.first;
        `RXG_ADDR_LATER: next_state.rdData = state.later;
        default:         next_state.rdData = `RXG_READ_UNMAPPED;
      endcase
    end

    // Clearing the forced cut leaves the receiver in a stale state until restarted; set wins over clear
    if (receiverRestart)
      next_state.restartPending = 1'b0;
    if (state.first[`RXG_B_FORCECUT] && !next_state.first[`RXG_B_FORCECUT])
      next_state.restartPending = 1'b1;

    // Single-ended mode has no usable driver reference, so the internal signal is forced
    next_state.mixInternal = singleEndedMode || next_state.front[`RXG_B_MIXCLK];

    // Squelch sequence; disabling automatic squelch aborts it at once
    case (state.sqState)
      rxg_pkg::SQ_IDLE:
      begin
        next_state.sqCnt = '0;
        if (txEnd && state.front[`RXG_B_SQUELCHAUTO])
          next_state.sqState = rxg_pkg::SQ_WAIT;
      end
      rxg_pkg::SQ_WAIT:
      begin
        next_state.sqCnt = state.sqCnt + 1'b1;
        if (state.sqCnt == SQ_LAST)
          next_state.sqState = rxg_pkg::SQ_ON;
      end
      rxg_pkg::SQ_ON:
      begin
        next_state.sqCnt = '0;
        if (maskTimerExpired)
          next_state.sqState = rxg_pkg::SQ_IDLE;
      end
      default:
      begin
        next_state.sqCnt   = '0;
        next_state.sqState = rxg_pkg::SQ_IDLE;
      end
    endcase
    if (!state.front[`RXG_B_SQUELCHAUTO])
      next_state.sqState = rxg_pkg::SQ_IDLE;

    // AGC window: whole receive period or the first eight sub-carrier pulses
    if (!rxActive)
      next_state.agcPulses = 4'h0;
    else if (subCarrierPulse && state.agcPulses != `RXG_AGC_PULSES)
      next_state.agcPulses = state.agcPulses + 4'h1;
    next_state.agcOn = state.front[`RXG_B_AGCEN] && rxActive &&
                       (state.front[`RXG_B_AGCFULL] || next_state.agcPulses != `RXG_AGC_PULSES);

    // Decoded later-stage gain, registered so outputs come from flops
    next_state.window = gainBus.windowSteps;
    next_state.cut    = gainBus.stageCut;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state             <= '0;
      state.front       <= `RXG_RST_FRONT;
      state.first       <= `RXG_RST_FIRST;
      state.later       <= `RXG_RST_LATER;
      state.laterActive <= `RXG_RST_LATER;
      state.sqState     <= rxg_pkg::SQ_IDLE;
    end
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state flops, except squelchActive decoded from sqState
  assign rdData                = state.rdData;
  assign lowPowerReceive       = state.front[`RXG_B_LOWPOWER];
  assign lowfreqSplitSelect    = state.front[`RXG_B_LFSPLIT];
  assign lfInputEnable         = state.front[`RXG_B_LFENABLE];
  assign agcEnable             = state.front[`RXG_B_AGCEN];
  assign agcResetAlgorithm     = state.front[`RXG_B_AGCRESET];
  assign agcActive             = state.agcOn;
  assign squelchActive         = (state.sqState == rxg_pkg::SQ_ON);
  assign phaseMixerClockSelect = state.mixInternal;
  assign amFirstStageGain      = state.first[`RXG_F_AMFIRST];
  assign pmFirstStageGain      = state.first[`RXG_F_PMFIRST];
  assign clipEnable            = state.first[`RXG_B_CLIP];
  assign forcedPeerGainCut     = state.first[`RXG_B_FORCECUT];
  assign restartPending        = state.restartPending;
  assign amLaterStageGain      = state.laterActive[`RXG_F_AMLATER];
  assign pmLaterStageGain      = state.laterActive[`RXG_F_PMLATER];
  assign amWindowSteps         = state.window[0];
  assign pmWindowSteps         = state.window[1];
  assign amStageCut            = state.cut[0];
  assign pmStageCut            = state.cut[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  frontWrite_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrFront && !setDefaultCmd |=> lowPowerReceive == $past(wrData[`RXG_B_LOWPOWER]) &&
                                  lowfreqSplitSelect == $past(wrData[`RXG_B_LFSPLIT]))
    else $error("Front control write not applied");

  readData_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdStrobe && regAddr == `RXG_ADDR_FIRST |=> rdData == $past(state.first))
    else $error("First-stage readback wrong");

  readIdle_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rdStrobe |=> rdData == `RXG_READ_UNMAPPED)
    else $error("Read data stand without a strobe");

  laterHeld_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !resetRxGainCmd && !setDefaultCmd |=> $stable(amLaterStageGain) && $stable(pmLaterStageGain))
    else $error("Later-stage gain changed without Reset Rx Gain");

  laterLoad_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    resetRxGainCmd && !setDefaultCmd |=> {amLaterStageGain, pmLaterStageGain} == $past(state.later))
    else $error("Reset Rx Gain did not load stored value");

  setDefault_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    setDefaultCmd |=> state.front == `RXG_RST_FRONT && state.first == `RXG_RST_FIRST &&
                      state.later == `RXG_RST_LATER)
    else $error("Set Default did not restore registers");

  mixerClock_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    singleEndedMode |=> phaseMixerClockSelect)
    else $error("Single-ended mode not using internal mixer clock");

  squelchDelay_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(squelchActive) |-> $past(state.sqCnt) == SQ_LAST && $past(state.sqState) == rxg_pkg::SQ_WAIT)
    else $error("Squelch started at wrong delay");

  squelchStop_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    squelchActive && maskTimerExpired |=> !squelchActive)
    else $error("Squelch not stopped at mask timer expiry");

  forcedCut_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    forcedPeerGainCut && $past(forcedPeerGainCut) |-> amStageCut == `RXG_FORCED_CUT &&
                                                     pmWindowSteps == `RXG_WINDOW_MAX)
    else $error("Forced cut not applied");

  restartFlag_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(forcedPeerGainCut) |-> restartPending)
    else $error("Restart not flagged after clearing forced cut");

  agcPulses_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    agcEnable && !state.front[`RXG_B_AGCFULL] && state.agcPulses == `RXG_AGC_PULSES && rxActive
    |=> !agcActive)
    else $error("AGC ran past eight pulses");

  // Register bus storage and readback
  firstWrite_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrFirst && !setDefaultCmd |=> {amFirstStageGain, pmFirstStageGain, clipEnable, forcedPeerGainCut} ==
                                  $past(wrData))
    else $error("First-stage write not applied");

  frontMisc_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrFront && !setDefaultCmd |=> lfInputEnable == $past(wrData[`RXG_B_LFENABLE]) &&
                                  agcResetAlgorithm == $past(wrData[`RXG_B_AGCRESET]))
    else $error("LF enable or AGC algorithm write not applied");

  mixerWrite_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrFront && !setDefaultCmd && !singleEndedMode |=> phaseMixerClockSelect == $past(wrData[`RXG_B_MIXCLK]))
    else $error("Mixer clock select does not follow the written bit");

  laterStore_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrLater && !setDefaultCmd |=> state.later == $past(wrData))
    else $error("Later-stage write not stored as written");

  readFront_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdStrobe && regAddr == `RXG_ADDR_FRONT |=> rdData == $past(state.front))
    else $error("Front control readback wrong");

  readLater_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdStrobe && regAddr == `RXG_ADDR_LATER |=> rdData == $past(state.later))
    else $error("Later-stage readback wrong");

  // Decoded later-stage gain trails the active code by one cycle
  amWindow_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(forcedPeerGainCut) && $past(amLaterStageGain) >= `RXG_WINDOW_MAX |->
      amWindowSteps == `RXG_WINDOW_MAX)
    else $error("AM digitizer window not at full width");

  pmCut_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(forcedPeerGainCut) && $past(pmLaterStageGain) >= `RXG_CODE_MAX |->
      pmStageCut == 3'(`RXG_CODE_MAX - `RXG_WINDOW_MAX))
    else $error("PM stage cut not at the largest step");

  // Squelch, AGC and restart
  squelchOff_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !state.front[`RXG_B_SQUELCHAUTO] |=> !squelchActive)
    else $error("Squelch active with automatic squelch disabled");

  agcOff_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !agcEnable || !rxActive |=> !agcActive)
    else $error("AGC active while disabled or outside receive");

  agcWhole_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    agcEnable && state.front[`RXG_B_AGCFULL] && rxActive |=> agcActive)
    else $error("AGC not active over the whole receive period");

  restartHold_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    restartPending && !receiverRestart |=> restartPending)
    else $error("Restart request dropped without a restart");

endmodule // rxg_config_regs

// File: rxg_gain_decode.sv
// Purpose: Decodes later-stage gain codes into digitizer window steps and stage cut steps per channel
// Assumes: Codes are the active values already loaded by Reset Rx Gain
// Notes:   One step is 3 dB for both outputs
`timescale 1ns/1ps
`include "rxg_params.svh"
module rxg_gain_decode
(
  rxg_gain_if.dec gain
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel decode
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : gChan
      logic [3:0] clamped;
      // Unused codes act as the strongest reduction rather than wrapping
      assign clamped = (gain.laterCode[ch] > `RXG_CODE_MAX) ? `RXG_CODE_MAX : gain.laterCode[ch];
      // Window widens first, then stage gain drops on top of the full window
      always_comb
      begin
        if (gain.forcedCut)
        begin
          gain.windowSteps[ch] = `RXG_WINDOW_MAX;
          gain.stageCut[ch]    = `RXG_FORCED_CUT;
        end
        else if (clamped > `RXG_WINDOW_MAX)
        begin
          gain.windowSteps[ch] = `RXG_WINDOW_MAX;
          gain.stageCut[ch]    = 3'(clamped - `RXG_WINDOW_MAX);
        end
        else
        begin
          gain.windowSteps[ch] = clamped;
          gain.stageCut[ch]    = 3'h0;
        end
      end
    end
  endgenerate

endmodule // rxg_gain_decode

// File: rxg_gain_if.sv
// Purpose: Carries the active later-stage codes to the decoder and the decoded settings back
// Assumes: Single clock domain, purely combinational path
// Notes:   Index 0 is the AM channel, index 1 the PM channel
`timescale 1ns/1ps
interface rxg_gain_if;
  logic [1:0][3:0] laterCode;
  logic            forcedCut;
  logic [1:0][3:0] windowSteps;
  logic [1:0][2:0] stageCut;

  modport ctrl (output laterCode, output forcedCut, input windowSteps, input stageCut);
  modport dec  (input laterCode, input forcedCut, output windowSteps, output stageCut);
endinterface // rxg_gain_if

// File: rxg_params.svh
// Purpose: Register offsets, defaults, field positions and timing figures of the receiver gain configuration bank
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef RXG_PARAMS_SVH
`define RXG_PARAMS_SVH

// Register map, 6-bit byte address
`define RXG_ADDR_W          6
`define RXG_ADDR_FRONT      6'h0B
`define RXG_ADDR_FIRST      6'h0C
`define RXG_ADDR_LATER      6'h0D

// Power-up and Set Default values
`define RXG_RST_FRONT       8'h1A
`define RXG_RST_FIRST       8'hD8
`define RXG_RST_LATER       8'h00
`define RXG_READ_UNMAPPED   8'h00

// Front control fields
`define RXG_B_LOWPOWER      7
`define RXG_B_LFSPLIT       6
`define RXG_B_LFENABLE      5
`define RXG_B_AGCEN         4
`define RXG_B_AGCFULL       3
`define RXG_B_AGCRESET      2
`define RXG_B_SQUELCHAUTO   1
`define RXG_B_MIXCLK        0

// First-stage gain fields
`define RXG_F_AMFIRST       7:5
`define RXG_F_PMFIRST       4:2
`define RXG_B_CLIP          1
`define RXG_B_FORCECUT      0

// Later-stage gain fields and code meaning
`define RXG_F_AMLATER       7:4
`define RXG_F_PMLATER       3:0
`define RXG_CODE_MAX        4'hA
`define RXG_WINDOW_MAX      4'h4
`define RXG_FORCED_CUT      3'h2
`define RXG_FIRST_BOOST     3'h7

// Timing
`define RXG_CLK_MHZ         40
`define RXG_SQ_DELAY_PS     18880000
`define RXG_AGC_PULSES      4'h8
`define RXG_SQ_CNT_W        10

`endif

// File: rxg_pkg.sv
// Purpose: Shared types of the receiver gain configuration bank
// Assumes: Used with package-qualified names only
// Notes:   Constants live in rxg_params.svh
package rxg_pkg;

  // Automatic squelch sequence after end of transmit
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_WAIT,
    SQ_ON
  } rxg_squelch_t;

endpackage

// File: tb_top.sv
// Purpose: Self-checking bench for the receiver gain configuration bank
// Assumes: Bench drives every input by non-blocking assignment at the rising edge of ref_clk
// Notes:   Outputs are sampled 1 ns after an edge so that the edge's updates have landed
`timescale 1ns/1ps
`include "rxg_params.svh"
module tb_top;
  logic                   ref_clk;
  logic                   rst_n;
  logic [`RXG_ADDR_W-1:0] regAddr;
  logic [7:0]             wrData;
  logic                   wrStrobe;
  logic                   rdStrobe;
  logic [7:0]             rdData;
  logic [5:0]             cmdBits;
  logic                   singleEndedMode;
  logic                   rxActive;
  logic [2:0]             amFirstStageGain, pmFirstStageGain, amStageCut, pmStageCut;
  logic [3:0]             amLaterStageGain, pmLaterStageGain, amWindowSteps, pmWindowSteps;
  logic                   lowPowerReceive, lowfreqSplitSelect, lfInputEnable, agcEnable, agcResetAlgorithm;
  logic                   agcActive, squelchActive, phaseMixerClockSelect, clipEnable, forcedPeerGainCut;
  logic                   restartPending;
  int                     nFail;
  int                     totalChecks;
  int                     k;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;

  // Command pulses share one vector so a single task can raise any of them
  rxg_config_regs uut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .setDefaultCmd(cmdBits[0]), .resetRxGainCmd(cmdBits[1]),
    .receiverRestart(cmdBits[2]), .singleEndedMode(singleEndedMode), .txEnd(cmdBits[3]),
    .maskTimerExpired(cmdBits[4]), .rxActive(rxActive), .subCarrierPulse(cmdBits[5]),
    .lowPowerReceive(lowPowerReceive), .lowfreqSplitSelect(lowfreqSplitSelect),
    .lfInputEnable(lfInputEnable), .agcEnable(agcEnable), .agcResetAlgorithm(agcResetAlgorithm),
    .agcActive(agcActive), .squelchActive(squelchActive), .phaseMixerClockSelect(phaseMixerClockSelect),
    .amFirstStageGain(amFirstStageGain), .pmFirstStageGain(pmFirstStageGain), .clipEnable(clipEnable),
    .forcedPeerGainCut(forcedPeerGainCut), .restartPending(restartPending),
    .amLaterStageGain(amLaterStageGain), .pmLaterStageGain(pmLaterStageGain),
    .amWindowSteps(amWindowSteps), .pmWindowSteps(pmWindowSteps), .amStageCut(amStageCut),
    .pmStageCut(pmStageCut)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus, command and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr  <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge ref_clk);
    cmdBits[b] <= 1'b1;
    @(posedge ref_clk);
    cmdBits[b] <= 1'b0;
    #1;
  endtask

  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic end_of_test();
    if (nFail == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(`RXG_ADDR_FRONT, 8'h1A);
    rd(`RXG_ADDR_FIRST, 8'hD8);
    rd(`RXG_ADDR_LATER, 8'h00);
    chk({agcEnable, squelchActive, forcedPeerGainCut}, 8'h04);
    wr(6'h0E, 8'hFF);
    rd(6'h0E, 8'h00);
    rd(6'h3F, 8'h00);
    rd(`RXG_ADDR_FRONT, 8'h1A);
  endtask

  // Each control bit of the front register walked high on its own
  task automatic t_front();
    for (k = 0; k < 8; k++)
    begin
      wr(`RXG_ADDR_FRONT, 8'h01 << k);
      chk({lowPowerReceive, lowfreqSplitSelect, lfInputEnable, agcEnable, 1'b0, agcResetAlgorithm, 1'b0,
           phaseMixerClockSelect}, (8'h01 << k) & 8'hF5);
      rd(`RXG_ADDR_FRONT, 8'h01 << k);
    end
    wr(`RXG_ADDR_FRONT, 8'h00);
    @(posedge ref_clk);
    singleEndedMode <= 1'b1;
    settle();
    chk({7'h00, phaseMixerClockSelect}, 8'h01);
    @(posedge ref_clk);
    singleEndedMode <= 1'b0;
    settle();
    chk({7'h00, phaseMixerClockSelect}, 8'h00);
  endtask

  task automatic t_first();
    wr(`RXG_ADDR_FIRST, 8'h3E);
    chk({amFirstStageGain, pmFirstStageGain, clipEnable, forcedPeerGainCut}, 8'h3E);
    rd(`RXG_ADDR_FIRST, 8'h3E);
    wr(`RXG_ADDR_FIRST, 8'hE1);
    settle();
    chk({amFirstStageGain, pmFirstStageGain, clipEnable, forcedPeerGainCut}, 8'hE1);
    chk({amWindowSteps, pmWindowSteps}, 8'h44);
    chk({1'b0, amStageCut, 1'b0, pmStageCut}, 8'h22);
    wr(`RXG_ADDR_FIRST, 8'h00);
    settle();
    chk({7'h00, restartPending}, 8'h01);
    pulse(2);
    settle();
    chk({7'h00, restartPending}, 8'h00);
  endtask

  // Every nibble code, including the unused ones, on both channels
  task automatic t_later();
    logic [3:0] w;
    logic [3:0] c;
    logic [7:0] prev;
    prev = 8'h00;
    for (k = 0; k < 16; k++)
    begin
      wr(`RXG_ADDR_LATER, {4'(k), 4'(15 - k)});
      settle();
      chk({amLaterStageGain, pmLaterStageGain}, prev);
      pulse(1);
      settle();
      prev = {4'(k), 4'(15 - k)};
      chk({amLaterStageGain, pmLaterStageGain}, prev);
      w = (k > 4) ? 4'h4 : 4'(k);
      c = (k > 10) ? 4'h6 : (k > 4) ? 4'(k - 4) : 4'h0;
      chk({amWindowSteps, 1'b0, amStageCut}, {w, c});
      w = (15 - k > 4) ? 4'h4 : 4'(15 - k);
      c = (15 - k > 10) ? 4'h6 : (15 - k > 4) ? 4'(11 - k) : 4'h0;
      chk({pmWindowSteps, 1'b0, pmStageCut}, {w, c});
      rd(`RXG_ADDR_LATER, prev);
    end
  endtask

  // Squelch rises 756 edges after the taken end of transmit: 18.9 us, the first whole cycle past the delay
  task automatic t_squelch();
    wr(`RXG_ADDR_FRONT, 8'h02);
    pulse(3);
    repeat (755) @(posedge ref_clk);
    #1;
    chk({7'h00, squelchActive}, 8'h00);
    settle();
    chk({7'h00, squelchActive}, 8'h01);
    pulse(4);
    settle();
    chk({7'h00, squelchActive}, 8'h00);
    wr(`RXG_ADDR_FRONT, 8'h00);
    pulse(3);
    repeat (800) @(posedge ref_clk);
    #1;
    chk({7'h00, squelchActive}, 8'h00);
  endtask

  task automatic t_agc();
    wr(`RXG_ADDR_FRONT, 8'h10);
    @(posedge ref_clk);
    rxActive <= 1'b1;
    repeat (7) pulse(5);
    settle();
    chk({7'h00, agcActive}, 8'h01);
    pulse(5);
    settle();
    chk({7'h00, agcActive}, 8'h00);
    // A new receive period must start the pulse count afresh
    @(posedge ref_clk);
    rxActive <= 1'b0;
    @(posedge ref_clk);
    rxActive <= 1'b1;
    settle();
    settle();
    chk({7'h00, agcActive}, 8'h01);
    @(posedge ref_clk);
    rxActive <= 1'b0;
    wr(`RXG_ADDR_FRONT, 8'h18);
    @(posedge ref_clk);
    rxActive <= 1'b1;
    repeat (10) pulse(5);
    settle();
    chk({7'h00, agcActive}, 8'h01);
    @(posedge ref_clk);
    rxActive <= 1'b0;
    settle();
    chk({7'h00, agcActive}, 8'h00);
  endtask

  task automatic t_default();
    wr(`RXG_ADDR_FRONT, 8'hE5);
    wr(`RXG_ADDR_FIRST, 8'h3C);
    wr(`RXG_ADDR_LATER, 8'h99);
    pulse(1);
    pulse(0);
    settle();
    rd(`RXG_ADDR_FRONT, 8'h1A);
    rd(`RXG_ADDR_FIRST, 8'hD8);
    rd(`RXG_ADDR_LATER, 8'h00);
    chk({amLaterStageGain, pmLaterStageGain}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence, reset held for 16 cycles
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    regAddr = '0;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    cmdBits = 6'h00;
    singleEndedMode = 1'b0;
    rxActive = 1'b0;
    nFail = 0;
    totalChecks = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_front();
    t_first();
    t_later();
    t_squelch();
    t_agc();
    t_default();
    end_of_test();
  end

  // Guard against a hang in any scenario
  initial
  begin
    #2500000;
    nFail++;
    end_of_test();
  end
endmodule // tb_top
